// *** rtl/ets_pkg.sv ***
// Package for the error and thermal sideband signalling block.
// Assumes a single 250 MHz core clock and a 100 MHz base bus clock
// edge delivered to the block as a one-cycle enable pulse.
package ets_pkg;

   // Base bus clock cycles that a machine-check error pulse lasts
   localparam logic [4:0] MCE_PULSE_BCLKS = 5'h10;

   // Die temperature in whole degrees C
   localparam int         TEMP_W        = 9;
   localparam logic [8:0] TRIP_TEMP_C   = 9'h082;
   localparam logic [8:0] HOT_TEMP_C    = 9'h064;

   // Fatal error output state
   typedef enum logic [1:0] {
      ETS_ERR_IDLE,
      ETS_ERR_PULSE,
      ETS_ERR_HELD
   } ets_err_state_t;

   // Sensor readings
   typedef struct packed {
      logic [8:0] temp_c;
      logic       valid;
   } ets_sensor_t;

   // Whole state of the block
   typedef struct packed {
      ets_err_state_t err_state;
      logic [4:0]     pulse_cnt;
      logic           hot_sync1;
      logic           hot_sync2;
      logic           hot_drive;
      logic           drive_d1;
      logic           drive_d2;
      logic           trip;
      logic           throttle;
   } ets_state_t;

endpackage

// *** rtl/ets_signal.sv ***
// Error and thermal sideband signalling for the processor side.
// Assumes the sensor reading, error events and bus clock enable come
// from logic on clk; the overheat line input comes from a board pin.
`timescale 1ns/10ps

module ets_signal (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               warm_reset,
   // Base bus clock edge, one cycle per 100 MHz period
   input  wire logic               bclk_en,
   // Error events, one-cycle pulses
   input  wire logic               machine_check_error,
   input  wire logic               internal_failure,
   // Thermal sensing and control
   input  wire ets_pkg::ets_sensor_t sensor,
   input  wire logic               throttle_enable,
   output logic                    thermal_throttle_circuit,
   output logic                    halt_execution,
   // Sideband pins
   output logic                    fatal_error_n,
   input  wire logic               overheat_throttle_n_in,
   output logic                    overheat_throttle_n_out,
   output logic                    overheat_throttle_n_oe,
   output logic                    overtemp_shutdown_n
);

   ets_pkg::ets_state_t st_r;
   ets_pkg::ets_state_t st_nxt;
   logic                hot_now;
   logic                trip_now;
   logic                ext_hot;
   logic                own_engage;
   logic                pulse_last;
   logic                err_start;
   logic                err_upgrade;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // True when a valid reading has reached the limit
   function automatic logic reading_at_least(
      ets_pkg::ets_sensor_t rd,
      logic [8:0]           limit
   );
      return rd.valid && (rd.temp_c >= limit);
   endfunction

   // True when a valid reading lies strictly beyond the limit
   function automatic logic reading_above(
      ets_pkg::ets_sensor_t rd,
      logic [8:0]           limit
   );
      return rd.valid && (rd.temp_c > limit);
   endfunction

   // True on the base clock edge that closes a machine-check pulse
   function automatic logic pulse_ends(
      logic [4:0] cnt,
      logic       bclk
   );
      return bclk && (cnt == (ets_pkg::MCE_PULSE_BCLKS - 5'h01));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Condition decode

   assign hot_now     = reading_at_least(sensor, ets_pkg::HOT_TEMP_C);
   assign trip_now    = reading_above(sensor, ets_pkg::TRIP_TEMP_C);

   // Our own pull on the line comes back through the pin two flops late.
   // Only a low level that we are not causing counts as an outside request,
   // else a disabled throttle would still engage from our own indication.
   // Limitation: an outside request is not seen while we pull the line.
   assign ext_hot     = st_r.hot_sync2 && !st_r.drive_d2;

   assign own_engage  = throttle_enable && hot_now;
   assign pulse_last  = pulse_ends(st_r.pulse_cnt, bclk_en);
   assign err_start   = internal_failure || machine_check_error;
   assign err_upgrade = internal_failure;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;

      // Pin passes two flops; only the second is looked at
      st_nxt.hot_sync1 = ~overheat_throttle_n_in;
      st_nxt.hot_sync2 = st_r.hot_sync1;

      // Own pull on the line, with copies delayed to match the synchroniser
      st_nxt.hot_drive = hot_now;
      st_nxt.drive_d1  = st_r.hot_drive;
      st_nxt.drive_d2  = st_r.drive_d1;

      // Throttle follows own heat when enabled, or an outside request
      st_nxt.throttle  = own_engage || ext_hot;

      // Trip is latched: execution stays stopped until cold reset
      if (trip_now) begin
         st_nxt.trip = 1'b1;
      end

      unique case (st_r.err_state)
         ets_pkg::ETS_ERR_IDLE: begin
            if (internal_failure) begin
               st_nxt.err_state = ets_pkg::ETS_ERR_HELD;
            end else if (err_start) begin
               st_nxt.err_state = ets_pkg::ETS_ERR_PULSE;
               st_nxt.pulse_cnt = '0;
            end
         end

         ets_pkg::ETS_ERR_PULSE: begin
            // Internal failure upgrades a running pulse to a held level;
            // a second machine check is not a retrigger
            if (err_upgrade) begin
               st_nxt.err_state = ets_pkg::ETS_ERR_HELD;
            end else if (pulse_last) begin
               st_nxt.err_state = ets_pkg::ETS_ERR_IDLE;
               st_nxt.pulse_cnt = '0;
            end else if (bclk_en) begin
               st_nxt.pulse_cnt = st_r.pulse_cnt + 5'h01;
            end
         end

         ets_pkg::ETS_ERR_HELD: begin
            st_nxt.err_state = ets_pkg::ETS_ERR_HELD;
         end

         default: begin
            st_nxt.err_state = ets_pkg::ETS_ERR_IDLE;
            st_nxt.pulse_cnt = '0;
         end
      endcase

      // Warm reset wins over a new event in the same cycle
      if (warm_reset) begin
         st_nxt.err_state = ets_pkg::ETS_ERR_IDLE;
         st_nxt.pulse_cnt = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{
            err_state: ets_pkg::ETS_ERR_IDLE,
            pulse_cnt: 5'h00,
            hot_sync1: 1'b0,
            hot_sync2: 1'b0,
            hot_drive: 1'b0,
            drive_d1:  1'b0,
            drive_d2:  1'b0,
            trip:      1'b0,
            throttle:  1'b0
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs: sideband pins active low, overheat_throttle_n_out open drain in style; halt_execution and thermal_throttle_circuit active high

   // Fatal error is low whenever the error machine is away from idle
   assign fatal_error_n            = (st_r.err_state == ets_pkg::ETS_ERR_IDLE);

   // Open drain: data is always low, the enable decides
   assign overheat_throttle_n_out  = 1'b0;
   assign overheat_throttle_n_oe   = st_r.hot_drive;

   assign overtemp_shutdown_n      = ~st_r.trip;
   assign halt_execution           = st_r.trip;
   assign thermal_throttle_circuit = st_r.throttle;
endmodule

// *** bench/ets_platform.sv ***
// Platform side model: pull-up on the overheat line plus an external hot source; device drives open drain.
`timescale 1ns/10ps
module ets_platform (
   input wire logic overheat_throttle_n_oe, overheat_throttle_n_out, ext_hot,
   output logic     overheat_throttle_n_in);
   // Pull-up holds the line high unless a party sinks it
   assign overheat_throttle_n_in = !(overheat_throttle_n_oe && !overheat_throttle_n_out || ext_hot);
endmodule

// *** bench/ets_signal_assertions.sv ***
// Checker for ets_signal; sees only its ports, bound at the foot.
`timescale 1ns/10ps
module ets_signal_assertions (
   input wire logic clk, rst_b, warm_reset, bclk_en, machine_check_error, internal_failure, throttle_enable,
   input wire ets_pkg::ets_sensor_t sensor,
   input wire logic thermal_throttle_circuit, halt_execution, fatal_error_n, overheat_throttle_n_in,
   input wire logic overheat_throttle_n_oe, overtemp_shutdown_n);
   logic [7:0] n_r;
   wire hot = sensor.valid && sensor.temp_c >= ets_pkg::HOT_TEMP_C;
   wire trip = sensor.valid && sensor.temp_c > ets_pkg::TRIP_TEMP_C;
   // Counts base clocks from the edge where the fatal line falls
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b) n_r <= '0;
      else n_r <= fatal_error_n ? 8'h00 : n_r + 8'(bclk_en);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence ext_hot_s; (!overheat_throttle_n_in && !overheat_throttle_n_oe) [*3]; endsequence
   err_start_a: assert property ((machine_check_error || internal_failure) && fatal_error_n && !warm_reset
      |=> !fatal_error_n) else $error("no start");
   warm_clear_a: assert property (warm_reset |=> fatal_error_n) else $error("no clear");
   pulse_len_a: assert property ($rose(fatal_error_n) |-> $past(warm_reset) || n_r == 8'h10)
      else $error("bad length");
   hot_drive_a: assert property (hot |=> overheat_throttle_n_oe) else $error("no hot");
   own_thr_a: assert property (hot && throttle_enable |=> thermal_throttle_circuit) else $error("no own");
   ext_thr_a: assert property (ext_hot_s |=> thermal_throttle_circuit) else $error("no ext");
   trip_set_a: assert property (trip |=> !overtemp_shutdown_n && halt_execution) else $error("no trip");
   no_trip_a: assert property (overtemp_shutdown_n && !trip |=> overtemp_shutdown_n) else $error("false");
endmodule
bind ets_signal ets_signal_assertions u_ets_signal_assertions (.*);

// *** bench/ets_signal_tb_top.sv ***
// Bench top: error pulses, random thermal traffic, external hot; platform model closes the pin.
`timescale 1ns/10ps
module ets_signal_tb_top;
   logic clk = 0, rst_b = 0, warm_reset = 0, bclk_en = 0, machine_check_error = 0, internal_failure = 0, ext_hot = 0;
   logic throttle_enable = 0, thermal_throttle_circuit, halt_execution, fatal_error_n, overtemp_shutdown_n;
   logic overheat_throttle_n_in, overheat_throttle_n_out, overheat_throttle_n_oe;
   ets_pkg::ets_sensor_t sensor = '0;
   logic [7:0] lf = 8'h4a;
   int mismatches = 0, n_compared = 0, cyc = 0, k;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %0t %h %h", $time, g, e); end end
   ets_signal u_ets_signal (.*);
   ets_platform u_ets_platform (.*);
   function automatic logic [7:0] nx(logic [7:0] v); return {v[6:0], ^(v & 8'hb8)}; endfunction
   task give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   always @(negedge clk) bclk_en <= cyc % 5 == 0 || cyc % 5 == 3;
   always @(posedge clk) if (++cyc > 3000) begin mismatches++; give_verdict; end
   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1;
      @(negedge clk) machine_check_error = 1;
      @(negedge clk) machine_check_error = 0;
      repeat (30) @(negedge clk);
      `CHK(fatal_error_n, 1'b0)
      machine_check_error = 1;
      @(negedge clk) machine_check_error = 0;
      repeat (13) @(negedge clk);
      `CHK(fatal_error_n, 1'b1)
      internal_failure = 1;
      @(negedge clk) internal_failure = 0;
      repeat (50) @(negedge clk);
      `CHK(fatal_error_n, 1'b0)
      warm_reset = 1;
      @(negedge clk) warm_reset = 0;
      `CHK(fatal_error_n, 1'b1)
      for (k = 0; k < 300; k++) begin
         lf = nx(lf);
         sensor = '{k ? 9'(lf) % 9'h083 : 9'h082, 1'b1};
         throttle_enable = lf[0];
         @(negedge clk) `CHK(overheat_throttle_n_oe, sensor.temp_c >= ets_pkg::HOT_TEMP_C)
         `CHK(thermal_throttle_circuit, throttle_enable && sensor.temp_c >= ets_pkg::HOT_TEMP_C)
      end
      sensor.temp_c = 9'h000;
      ext_hot = 1;
      repeat (5) @(negedge clk);
      `CHK(thermal_throttle_circuit, 1'b1)
      sensor.temp_c = 9'h083;
      @(negedge clk) `CHK({overtemp_shutdown_n, halt_execution}, 2'b01)
      sensor.temp_c = 9'h000;
      internal_failure = 1;
      @(negedge clk) internal_failure = 0;
      `CHK(fatal_error_n, 1'b0)
      rst_b = 0;
      @(negedge clk) rst_b = 1;
      @(negedge clk) `CHK({fatal_error_n, overtemp_shutdown_n, halt_execution}, 3'b110)
      give_verdict;
   end
endmodule
